//--- src/rexc_pkg.sv
// Constants and types for the redundant exciter changeover selector.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
// Functional notes
// - Fault on the primary while serving moves service to the standby unit.
// - Jumper selects fault source: exciter health output or RF detect at relay.
// - Changeover order: power off, move RF relay, move modulation, power on.
// - Output interlock is held active for the whole switching sequence.
// - Automatic mode starts a five-minute timer on standby, then retries primary.
// - A successful retry stays on the primary with normal supervision.
// - A failed retry returns to standby permanently and latches primary faulty.
// - Manual mode retries only after manual reset or power-up.
// - Status outputs continuously show active unit, state and fault flags.
// - Remote reset input acts exactly as the local reset input.
// - Default and idle outputs leave the primary powered, routed and enabled.
package rexc_pkg;

  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned RETRY_TIME_S    = 300;
  // Five minutes at 25 MHz does not fit in 32 bits
  localparam longint unsigned RETRY_CYCLES = 64'(RETRY_TIME_S) * CLK_HZ;
  localparam int unsigned STEP_TIME_US    = 2_000;
  localparam int unsigned STEP_CYCLES     = STEP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_TIME_MS  = 1_000;
  localparam int unsigned SETTLE_CYCLES   = SETTLE_TIME_MS * (CLK_HZ / 1_000);
  localparam int unsigned CNT_W           = 34;

  // Sequence states, Gray-coded along the path from SERVE through PWRON to SETTLE
  typedef enum logic [3:0] {
    REXC_ST_SERVE  = 4'h0,
    REXC_ST_PWROFF = 4'h1,
    REXC_ST_RELAY  = 4'h3,
    REXC_ST_MOD    = 4'h2,
    REXC_ST_PWRON  = 4'h6,
    REXC_ST_SETTLE = 4'h7,
    REXC_ST_WAIT   = 4'h5
  } rexc_state_e;

endpackage

//--- src/rexc_timer.sv
// Down-counting delay timer used for step, settle and retry intervals.
// Assumes the load pulse and the count are synchronous to core_clk_i.
`timescale 1ns/100ps
module rexc_timer #(
  parameter int unsigned W = 34
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // Status
  output logic              done_o
);

  logic [W-1:0] count_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= value_i;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i || load_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (count_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule

//--- src/rexc_selector.sv
// Changeover sequencer for a one-plus-one primary and standby exciter pair.
// Assumes all inputs synchronous to core_clk_i; jumper and mode are static levels.
`timescale 1ns/100ps
module rexc_selector
  import rexc_pkg::*;
#(
  parameter longint unsigned RETRY_CNT = rexc_pkg::RETRY_CYCLES,
  parameter int unsigned STEP_CNT   = rexc_pkg::STEP_CYCLES,
  parameter int unsigned SETTLE_CNT = rexc_pkg::SETTLE_CYCLES
) (
  // Clock and resets
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic remote_reset_i,
  // Configuration
  input  wire logic fault_src_rf_i,
  input  wire logic auto_mode_i,
  // Fault sources
  input  wire logic pri_health_i,
  input  wire logic sby_health_i,
  input  wire logic pri_rf_det_i,
  input  wire logic sby_rf_det_i,
  // Exciter and relay controls
  output logic      pri_power_off_o,
  output logic      sby_power_on_o,
  output logic      relay_sby_o,
  output logic      mod_sby_o,
  output logic      interlock_o,
  // Status
  output logic      on_standby_o,
  output logic      pri_faulty_o,
  output logic      sby_fault_o,
  output logic      busy_o,
  output logic      retry_wait_o
);

  import rexc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  rexc_state_e state_reg;
  logic        to_sby_reg;
  logic        retried_reg;
  logic        faulty_reg;
  logic        tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic        tmr_done;
  logic        rst;
  logic        pri_ok;
  logic        sby_ok;
  logic        settle_fail;

  assign rst = reset_i | remote_reset_i;

  // Fault source selected by jumper; levels used directly
  assign pri_ok = fault_src_rf_i ? pri_rf_det_i : pri_health_i;
  assign sby_ok = fault_src_rf_i ? sby_rf_det_i : sby_health_i;

  // Primary RF is still muted in the first settle cycle; judge it once unmuted
  assign settle_fail = (state_reg == REXC_ST_SETTLE) && !interlock_o && !pri_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Timer load selection

  always_comb begin
    tmr_load  = 1'b0;
    tmr_value = CNT_W'(STEP_CNT);
    unique case (state_reg)
      REXC_ST_SERVE: begin
        tmr_load = !to_sby_reg && !pri_ok;
      end
      REXC_ST_PWROFF, REXC_ST_RELAY, REXC_ST_MOD: begin
        tmr_load = tmr_done;
      end
      REXC_ST_PWRON: begin
        tmr_load = tmr_done;
        if (to_sby_reg) begin
          tmr_value = CNT_W'(RETRY_CNT);
        end else if (retried_reg) begin
          tmr_value = CNT_W'(SETTLE_CNT);
        end
      end
      REXC_ST_SETTLE: begin
        tmr_load = settle_fail;
      end
      REXC_ST_WAIT: begin
        tmr_load = tmr_done && auto_mode_i && !faulty_reg;
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  rexc_timer #(
    .W (CNT_W)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .reset_i    (rst),
    .load_i     (tmr_load),
    .value_i    (tmr_value),
    .done_o     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      state_reg  <= REXC_ST_SERVE;
      to_sby_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        REXC_ST_SERVE: begin
          if (!to_sby_reg && !pri_ok) begin
            state_reg  <= REXC_ST_PWROFF;
            to_sby_reg <= 1'b1;
          end
        end
        REXC_ST_PWROFF: if (tmr_done) state_reg <= REXC_ST_RELAY;
        REXC_ST_RELAY:  if (tmr_done) state_reg <= REXC_ST_MOD;
        REXC_ST_MOD:    if (tmr_done) state_reg <= REXC_ST_PWRON;
        REXC_ST_PWRON: begin
          if (tmr_done) begin
            if (to_sby_reg) begin
              state_reg <= REXC_ST_WAIT;
            end else if (retried_reg) begin
              state_reg <= REXC_ST_SETTLE;
            end else begin
              state_reg <= REXC_ST_SERVE;
            end
          end
        end
        REXC_ST_SETTLE: begin
          if (settle_fail) begin
            state_reg  <= REXC_ST_PWROFF;
            to_sby_reg <= 1'b1;
          end else if (tmr_done) begin
            state_reg <= REXC_ST_SERVE;
          end
        end
        REXC_ST_WAIT: begin
          // Manual mode or latched fault: stay on standby
          if (tmr_done && auto_mode_i && !faulty_reg) begin
            state_reg  <= REXC_ST_PWROFF;
            to_sby_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= REXC_ST_SERVE;
        end
      endcase
    end
  end

  // Retry tracking and permanent primary fault flag
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      retried_reg <= 1'b0;
      faulty_reg  <= 1'b0;
    end else begin
      if (state_reg == REXC_ST_WAIT && tmr_load) begin
        retried_reg <= 1'b1;
      end else if (state_reg == REXC_ST_SETTLE && !settle_fail && tmr_done) begin
        retried_reg <= 1'b0;
      end
      if (settle_fail) begin
        faulty_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      pri_power_off_o <= 1'b0;
      sby_power_on_o  <= 1'b0;
      relay_sby_o     <= 1'b0;
      mod_sby_o       <= 1'b0;
      interlock_o     <= 1'b0;
    end else begin
      unique case (state_reg)
        REXC_ST_PWROFF: begin
          interlock_o     <= 1'b1;
          pri_power_off_o <= 1'b1;
          sby_power_on_o  <= 1'b0;
        end
        REXC_ST_RELAY: begin
          interlock_o <= 1'b1;
          relay_sby_o <= to_sby_reg;
        end
        REXC_ST_MOD: begin
          interlock_o <= 1'b1;
          mod_sby_o   <= to_sby_reg;
        end
        REXC_ST_PWRON: begin
          interlock_o     <= 1'b1;
          pri_power_off_o <= to_sby_reg;
          sby_power_on_o  <= to_sby_reg;
        end
        default: begin
          interlock_o <= 1'b0;
        end
      endcase
    end
  end

  // Status for remote monitoring
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      on_standby_o <= 1'b0;
      pri_faulty_o <= 1'b0;
      sby_fault_o  <= 1'b0;
      busy_o       <= 1'b0;
      retry_wait_o <= 1'b0;
    end else begin
      on_standby_o <= to_sby_reg;
      pri_faulty_o <= faulty_reg || settle_fail;
      sby_fault_o  <= to_sby_reg && !sby_ok;
      busy_o       <= (state_reg != REXC_ST_SERVE) && (state_reg != REXC_ST_WAIT);
      retry_wait_o <= (state_reg == REXC_ST_WAIT) && auto_mode_i && !faulty_reg;
    end
  end

endmodule

//--- tb/rexc_exciters.sv
// Partner model: primary and standby exciters with RF detect at the relay.
// Assumes fault injection from the bench; all levels are plain logic.
`timescale 1ns/100ps
module rexc_exciters (
  // Controls from the selector
  input  wire logic       pri_power_off_i,
  input  wire logic       sby_power_on_i,
  input  wire logic       interlock_i,
  // Fault injection, bit 0 health, bit 1 RF
  input  wire logic [1:0] pri_fail_i,
  input  wire logic [1:0] sby_fail_i,
  // Indications
  output logic            pri_health_o,
  output logic            sby_health_o,
  output logic            pri_rf_det_o,
  output logic            sby_rf_det_o
);
  assign pri_health_o = !pri_power_off_i && !pri_fail_i[0];
  assign sby_health_o = sby_power_on_i && !sby_fail_i[0];
  // RF is muted while the interlock is held
  assign pri_rf_det_o = !pri_power_off_i && !interlock_i && !pri_fail_i[1];
  assign sby_rf_det_o = sby_power_on_i && !interlock_i && !sby_fail_i[1];
endmodule

//--- tb/rexc_selector_props.sv
// Checker for the changeover selector ports.
// Bound into rexc_selector; sees only its ports.
`timescale 1ns/100ps
module rexc_selector_props (
  // Clock and resets
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic remote_reset_i,
  // Inputs
  input wire logic fault_src_rf_i,
  input wire logic auto_mode_i,
  input wire logic pri_health_i,
  // Outputs
  input wire logic pri_power_off_o,
  input wire logic sby_power_on_o,
  input wire logic relay_sby_o,
  input wire logic mod_sby_o,
  input wire logic interlock_o,
  input wire logic on_standby_o,
  input wire logic pri_faulty_o,
  input wire logic busy_o,
  input wire logic retry_wait_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i || remote_reset_i);
  ////////////////////////////////////////////////////////////
  chk_fault_start: assert property (!busy_o && !on_standby_o && !fault_src_rf_i
    && !pri_health_i |-> ##2 interlock_o && pri_power_off_o && on_standby_o)
    else $error("changeover did not start");
  chk_relay_cold: assert property ($changed(relay_sby_o) |-> interlock_o)
    else $error("relay moved unmuted");
  chk_relay_order: assert property ($rose(relay_sby_o) |-> pri_power_off_o)
    else $error("relay before power off");
  chk_mod_order: assert property ($rose(mod_sby_o) |-> relay_sby_o)
    else $error("modulation before relay");
  chk_power_order: assert property ($rose(sby_power_on_o) |-> mod_sby_o && interlock_o)
    else $error("power on out of order");
  chk_idle_primary: assert property (!on_standby_o && !busy_o |-> !pri_power_off_o
    && !relay_sby_o && !interlock_o)
    else $error("idle without primary");
  chk_manual_hold: assert property (on_standby_o && !busy_o && !auto_mode_i
    |=> on_standby_o)
    else $error("manual mode left standby");
  chk_fault_latch: assert property (pri_faulty_o |=> pri_faulty_o)
    else $error("faulty flag dropped");
  chk_wait_flag: assert property (retry_wait_o |-> on_standby_o && !pri_faulty_o)
    else $error("retry wait flag wrong");
  chk_reset_clear: assert property (disable iff (1'b0) reset_i || remote_reset_i
    |=> !on_standby_o && !interlock_o && !pri_faulty_o)
    else $error("reset did not clear");
endmodule

//--- tb/tb_rexc_selector.sv
// Self-checking bench for the changeover selector.
// Assumes shortened timer parameters; checker is bound at the foot.
`timescale 1ns/100ps
module tb_rexc_selector;
  import rexc_pkg::*;
  localparam int unsigned RETRY  = 200;
  localparam int unsigned STEP   = 5;
  localparam int unsigned SETTLE = 20;
  logic        core_clk_i     = 1'b0;
  logic        reset_i        = 1'b1;
  logic        remote_reset_i = 1'b0;
  logic        fault_src_rf_i = 1'b0;
  logic        auto_mode_i    = 1'b0;
  logic [1:0]  pri_fail       = 2'h0;
  logic [1:0]  sby_fail       = 2'h0;
  logic [31:0] seed           = 32'hA881569F;
  logic        pri_health_i, sby_health_i, pri_rf_det_i, sby_rf_det_i;
  logic        pri_power_off_o, sby_power_on_o, relay_sby_o, mod_sby_o, interlock_o;
  logic        on_standby_o, pri_faulty_o, sby_fault_o, busy_o, retry_wait_o;
  int          errors         = 0;
  int          cmp_count      = 0;
  always #20 core_clk_i = ~core_clk_i;
  rexc_selector #(.RETRY_CNT(RETRY), .STEP_CNT(STEP), .SETTLE_CNT(SETTLE)) i_dut (.*);
  rexc_exciters i_exc (
    .pri_power_off_i(pri_power_off_o), .sby_power_on_i(sby_power_on_o),
    .interlock_i(interlock_o), .pri_fail_i(pri_fail), .sby_fail_i(sby_fail),
    .pri_health_o(pri_health_i), .sby_health_o(sby_health_i),
    .pri_rf_det_o(pri_rf_det_i), .sby_rf_det_o(sby_rf_det_i)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic exp_sf(input logic src, input logic [1:0] f);
    return src ? f[1] : f[0];
  endfunction
  task automatic final_report();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input int id);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t mismatch at check %0d", $time, id);
    end
  endtask
  task automatic wt(input int sel, input logic lvl, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(negedge core_clk_i);
      s = sel == 0 ? busy_o : sel == 1 ? on_standby_o : pri_faulty_o;
      if (s === lvl) return;
    end
    errors++;
    $display("ERROR %0t wait timed out", $time);
    final_report();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    chk(pri_power_off_o | relay_sby_o | interlock_o | on_standby_o, 1'b0, 1);
    seed = xs(seed);
    repeat (seed[2:0]) @(negedge core_clk_i);
    pri_fail = 2'h1;
    wt(0, 1'b1, 8);
    chk(interlock_o, 1'b1, 2);
    wt(0, 1'b0, 4 * STEP + 20);
    chk(relay_sby_o & mod_sby_o & sby_power_on_o & pri_power_off_o, 1'b1, 3);
    chk(interlock_o | retry_wait_o, 1'b0, 4);
    pri_fail = 2'h0;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sby_fail = seed[1:0];
      repeat (40) @(negedge core_clk_i);
      chk(sby_fault_o, exp_sf(fault_src_rf_i, sby_fail), 5);
    end
    sby_fail = 2'h0;
    chk(on_standby_o, 1'b1, 6);
    remote_reset_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    remote_reset_i = 1'b0;
    @(negedge core_clk_i);
    chk(on_standby_o | pri_power_off_o | pri_faulty_o, 1'b0, 7);
    fault_src_rf_i = 1'b1;
    auto_mode_i = 1'b1;
    pri_fail = 2'h1;
    repeat (20) @(negedge core_clk_i);
    chk(busy_o | on_standby_o, 1'b0, 8);
    pri_fail = 2'h2;
    wt(1, 1'b1, 8);
    wt(0, 1'b0, 4 * STEP + 20);
    chk(retry_wait_o, 1'b1, 9);
    pri_fail = 2'h0;
    repeat (RETRY - 20) @(negedge core_clk_i);
    chk(on_standby_o & !busy_o, 1'b1, 10);
    wt(1, 1'b0, 60);
    wt(0, 1'b0, 4 * STEP + SETTLE + 20);
    chk(on_standby_o | pri_faulty_o | interlock_o, 1'b0, 11);
    pri_fail = 2'h2;
    wt(1, 1'b1, 8);
    wt(2, 1'b1, RETRY + 8 * STEP + SETTLE + 60);
    wt(0, 1'b0, 4 * STEP + 20);
    chk(on_standby_o & relay_sby_o & sby_power_on_o, 1'b1, 12);
    repeat (RETRY + 50) @(negedge core_clk_i);
    chk(on_standby_o & pri_faulty_o & !retry_wait_o, 1'b1, 13);
    final_report();
  end
endmodule
bind rexc_selector rexc_selector_props i_props (.*);
